// ===== twop_pkg.sv
/*
 * Shared constants and carrier types for the trace word output port.
 * Assumes one core clock domain; imported by the trace port and the bench.
 */
package twop_pkg;

    // Trace word geometry.
    localparam int          TWOP_WORD_W    = 64;
    localparam int          TWOP_CNT_W     = 3;
    localparam int          TWOP_REM_W     = 7;
    localparam logic [6:0]  TWOP_REM_FULL  = 7'h40;
    localparam logic [6:0]  TWOP_REM_ZERO  = 7'h00;
    localparam logic [6:0]  TWOP_CHUNK_MIN = 7'h04;

    // Bit count encoding that marks a whole word per core cycle.
    localparam logic [2:0]  TWOP_BITS_FULL = 3'h4;

    // Trace cycle length in core cycles; the narrowest chunk takes longest.
    localparam int          TWOP_TCYC_W    = 5;
    localparam logic [4:0]  TWOP_TCYC_MAX  = 5'h10;
    localparam logic [4:0]  TWOP_TCYC_ONE  = 5'h01;
    localparam logic [4:0]  TWOP_TCYC_ZERO = 5'h00;

    // Trace word offered by the core's trace generator.
    typedef struct packed {
        logic                   valid;
        logic [TWOP_WORD_W-1:0] data;
    } twop_src_t;

    // Trigger requests raised by the core's own debug logic.
    typedef struct packed {
        logic probe;
        logic onchip;
    } twop_trig_t;

    // Probe strobe states, one-hot.
    typedef enum logic [1:0] {
        TWOP_STB_IDLE = 2'b01,
        TWOP_STB_HIGH = 2'b10
    } twop_stb_state_t;

endpackage

// ===== twop_trig_sync.sv
/*
 * Two-stage synchroniser with rising edge detector for one trigger pin.
 * Assumes the input is asynchronous to sys_clk and may change at any time.
 */
`timescale 1ns/10ps

module twop_trig_sync
(
    sys_clk,
    rst_b,
    async_in,
    edge_pulse
);
    input  wire logic sys_clk;
    input  wire logic rst_b;
    input  wire logic async_in;
    output logic      edge_pulse;

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // The first stage feeds only the second; nothing else looks at it.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    // Keep the previous settled sample for edge detection.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            last_reg <= 1'b0;
        else
            last_reg <= sync_reg;
    end

    // One event per rising edge of the settled level.
    assign edge_pulse = sync_reg && !last_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_sync_two_stage: assert property (
        edge_pulse |-> $past(async_in, 2) && !$past(async_in, 3))
        else $error("Trigger event without a synchronised rising edge.");

    a_edge_single_pulse: assert property (
        edge_pulse |=> !edge_pulse)
        else $error("Trigger event lasted more than one cycle.");

endmodule

// ===== twop_trace_port.sv
/*
 * Trace word output port: shifts trace words toward the probe interface
 * unit, flags whole words with a valid/hold handshake, and carries the
 * trigger inputs and strobes. Assumes the trace generator and the probe
 * interface unit run on sys_clk; the trigger pins are asynchronous.
 */
//
// Notes on behaviour
// - Valid is only ever high while the bit count shows the full-word code.
// - Valid rises in the first cycle a new word fills the whole bus.
// - Hold freezes data and valid until the cycle after hold is seen low.
// - Hold is looked at only before a new word in full-word mode.
// - In narrow modes the word on the bus shifts down by the chunk the bit count selects.
// - Both trigger inputs pass a two-stage synchroniser before use.
// - Probe trigger strobe stays high for exactly one trace cycle.
// - On-chip trigger strobe stays high for exactly one core cycle.
`timescale 1ns/10ps

module twop_trace_port
#(
    parameter int WORD_W = 64
)
(
    sys_clk,
    rst_b,
    src,
    src_ready,
    trace_bit_count,
    trace_hold_request,
    trace_word_bits,
    trace_word_valid,
    trig_req,
    probe_trigger_in,
    onchip_trigger_in,
    probe_trig_event,
    onchip_trig_event,
    probe_trigger_out,
    onchip_trigger_out
);
    import twop_pkg::*;

    input  wire logic                  sys_clk;
    input  wire twop_pkg::twop_src_t   src;
    input  wire logic                  rst_b;
    output logic                       src_ready;
    input  wire logic [2:0]            trace_bit_count;
    input  wire logic                  trace_hold_request;
    output logic [WORD_W-1:0]          trace_word_bits;
    output logic                       trace_word_valid;
    input  wire twop_pkg::twop_trig_t  trig_req;
    input  wire logic                  probe_trigger_in;
    input  wire logic                  onchip_trigger_in;
    output logic                       probe_trig_event;
    output logic                       onchip_trig_event;
    output logic                       probe_trigger_out;
    output logic                       onchip_trigger_out;

    // The shift counter and chunk sizes are built for the 64-bit word.
    if (WORD_W != TWOP_WORD_W)
    begin : g_bad_width
        $error("twop_trace_port supports only a 64-bit trace word.");
    end

    logic [WORD_W-1:0]      data_reg;
    logic                   valid_reg;
    logic [TWOP_REM_W-1:0]  rem_reg;
    logic [TWOP_REM_W-1:0]  chunk;
    logic [TWOP_TCYC_W-1:0] tcyc_len;
    logic                   full_mode;
    twop_stb_state_t        stb_reg;
    logic [TWOP_TCYC_W-1:0] stb_cnt_reg;
    logic                   chip_out_reg;

    // Bits handed to the probe unit per core cycle for each count code.
    function automatic logic [TWOP_REM_W-1:0] chunk_of(logic [2:0] code);
        logic [TWOP_REM_W-1:0] r;
        r = TWOP_REM_FULL;
        if (code < TWOP_BITS_FULL)
            r = TWOP_REM_W'(TWOP_CHUNK_MIN << code);
        return r;
    endfunction

    // Core cycles needed to move one word; this is one trace cycle.
    function automatic logic [TWOP_TCYC_W-1:0] tcyc_of(logic [2:0] code);
        logic [TWOP_TCYC_W-1:0] r;
        r = TWOP_TCYC_ONE;
        if (code < TWOP_BITS_FULL)
            r = TWOP_TCYC_W'(TWOP_TCYC_MAX >> code);
        return r;
    endfunction

    assign full_mode = (trace_bit_count == TWOP_BITS_FULL);
    assign chunk     = chunk_of(trace_bit_count);
    assign tcyc_len  = tcyc_of(trace_bit_count);

    // In full-word mode only hold stops the next word; hold is ignored in
    // narrow modes, where a word is taken once its last chunk goes out.
    assign src_ready = full_mode ? !trace_hold_request
                                 : (rem_reg <= chunk);

    // Trace data path: load a fresh word, shift down, or freeze under hold.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_reg <= '0;
            rem_reg  <= TWOP_REM_ZERO;
        end
        else if (full_mode)
        begin
            if (!trace_hold_request && src.valid)
            begin
                data_reg <= src.data;
                rem_reg  <= TWOP_REM_ZERO;
            end
        end
        else if (src_ready && src.valid)
        begin
            data_reg <= src.data;
            rem_reg  <= TWOP_REM_FULL;
        end
        else
        begin
            data_reg <= data_reg >> chunk;
            if (src_ready)
                rem_reg <= TWOP_REM_ZERO;
            else
                rem_reg <= rem_reg - chunk;
        end
    end

    // Valid flag: rises with each new whole word, held static under hold.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            valid_reg <= 1'b0;
        else if (!full_mode)
            valid_reg <= 1'b0;
        else if (!trace_hold_request)
            valid_reg <= src.valid;
    end

    // Gating by the live count keeps valid off the moment the mode changes.
    assign trace_word_valid = valid_reg && full_mode;
    assign trace_word_bits  = data_reg;

    // Trigger pins in: one synchroniser and edge detector each.
    twop_trig_sync u_probe_sync
    (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .async_in   (probe_trigger_in),
        .edge_pulse (probe_trig_event)
    );

    twop_trig_sync u_onchip_sync
    (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .async_in   (onchip_trigger_in),
        .edge_pulse (onchip_trig_event)
    );

    // Probe strobe: stretched over one trace cycle so a slow probe sees it.
    // Requests arriving while the strobe is high are merged into it.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stb_reg     <= TWOP_STB_IDLE;
            stb_cnt_reg <= TWOP_TCYC_ZERO;
        end
        else
        begin
            case (stb_reg)
                TWOP_STB_IDLE:
                begin
                    if (trig_req.probe)
                    begin
                        stb_reg     <= TWOP_STB_HIGH;
                        stb_cnt_reg <= tcyc_len - TWOP_TCYC_ONE;
                    end
                end
                TWOP_STB_HIGH:
                begin
                    if (stb_cnt_reg == TWOP_TCYC_ZERO)
                        stb_reg <= TWOP_STB_IDLE;
                    else
                        stb_cnt_reg <= stb_cnt_reg - TWOP_TCYC_ONE;
                end
                default:
                begin
                    stb_reg     <= TWOP_STB_IDLE;
                    stb_cnt_reg <= TWOP_TCYC_ZERO;
                end
            endcase
        end
    end

    assign probe_trigger_out = (stb_reg == TWOP_STB_HIGH);

    // On-chip strobe: one core cycle; a held request pulses every second cycle.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            chip_out_reg <= 1'b0;
        else
            chip_out_reg <= trig_req.onchip && !chip_out_reg;
    end

    assign onchip_trigger_out = chip_out_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_valid_full_only: assert property (
        trace_word_valid |-> trace_bit_count == TWOP_BITS_FULL)
        else $error("Valid seen outside full-word mode.");

    a_valid_new_word: assert property (
        full_mode && !trace_hold_request && src.valid |=>
            !full_mode || (trace_word_valid && trace_word_bits == $past(src.data)))
        else $error("New whole word not flagged valid on the next cycle.");

    a_hold_freezes: assert property (
        full_mode && trace_hold_request |=>
            $stable(trace_word_bits) && $stable(valid_reg))
        else $error("Data or valid moved while hold was high.");

    a_hold_release: assert property (
        full_mode && trace_hold_request ##1
            full_mode && !trace_hold_request && src.valid |=>
            trace_word_bits == $past(src.data))
        else $error("Word not released the cycle after hold went low.");

    // A narrow-mode take under hold must still load the offered word.
    a_hold_ignored: assert property (
        !full_mode && trace_hold_request && src.valid && rem_reg <= chunk
            |=> trace_word_bits == $past(src.data))
        else $error("Hold obeyed outside full-word mode.");

    a_shift_down: assert property (
        !full_mode && rem_reg > chunk |=>
            trace_word_bits == $past(data_reg) >> $past(chunk))
        else $error("Narrow mode did not shift the word down.");

    a_probe_full_len: assert property (
        $rose(probe_trigger_out) && $past(full_mode) |=> !probe_trigger_out)
        else $error("Probe strobe longer than one trace cycle.");

    a_probe_half_len: assert property (
        $rose(probe_trigger_out) && $past(trace_bit_count) == 3'h3 |->
            probe_trigger_out ##1 probe_trigger_out ##1 !probe_trigger_out)
        else $error("Probe strobe not two cycles in 32-bit mode.");

    a_chip_strobe: assert property (
        trig_req.onchip && !onchip_trigger_out |=>
            onchip_trigger_out ##1 !onchip_trigger_out)
        else $error("On-chip strobe not exactly one cycle.");

    c_stall_seen: cover property (
        trace_word_valid && trace_hold_request ##1 trace_word_valid);
    c_narrow_word: cover property (
        !full_mode && src_ready && src.valid ##1 !src_ready);
    c_probe_long: cover property (
        probe_trigger_out [*4]);
    c_trig_in: cover property (
        probe_trig_event ##[1:20] onchip_trig_event);

endmodule

// ===== twop_piu_model.sv
/*
 * Behavioural model of the probe interface unit on the trace port.
 * Assumes the bench picks bit count and hold on sys_clk rising edges.
 */
`timescale 1ns/10ps

module twop_piu_model
(
    sys_clk,
    trace_word_bits,
    trace_word_valid,
    cfg_count,
    cfg_hold,
    trace_bit_count,
    trace_hold_request,
    lane_bits,
    got_word
);
    input  wire logic        sys_clk;
    input  wire logic [63:0] trace_word_bits;
    input  wire logic        trace_word_valid;
    input  wire logic [2:0]  cfg_count;
    input  wire logic        cfg_hold;
    output logic [2:0]       trace_bit_count;
    output logic             trace_hold_request;
    output logic [15:0]      lane_bits;
    output logic [63:0]      got_word;

    // Hold stands as long as the bench wants a slow probe.
    assign trace_bit_count    = cfg_count;
    assign trace_hold_request = cfg_hold;

    // Only the low N pins are wired; N is 4, 8 or 16 here.
    assign lane_bits = trace_word_bits[15:0]
                     & ~(16'hffff << (4 << cfg_count));

    // Whole words are taken only when valid and not held back.
    always_ff @(posedge sys_clk)
    begin
        if (trace_word_valid && !trace_hold_request)
            got_word <= trace_word_bits;
    end
endmodule

// ===== testbench.sv
/*
 * Self-checking bench for the trace word output port.
 * Assumes the probe unit model on the far side; assertions live in design.
 */
`timescale 1ns/10ps

module testbench;
    import twop_pkg::*;
    logic        sys_clk;
    logic        rst_b;
    twop_src_t   src;
    logic        src_ready;
    logic [2:0]  cfg_count;
    logic        cfg_hold;
    logic [2:0]  trace_bit_count;
    logic        trace_hold_request;
    logic [63:0] trace_word_bits;
    logic        trace_word_valid;
    twop_trig_t  trig_req;
    logic        probe_trigger_in;
    logic        onchip_trigger_in;
    logic        probe_trig_event;
    logic        onchip_trig_event;
    logic        probe_trigger_out;
    logic        onchip_trigger_out;
    logic [15:0] lane_bits;
    logic [63:0] got_word;
    int          err_count;
    int          total_checks;

    twop_trace_port u_twop_trace_port (.sys_clk(sys_clk), .rst_b(rst_b),
        .src(src), .src_ready(src_ready), .trace_bit_count(trace_bit_count),
        .trace_hold_request(trace_hold_request),
        .trace_word_bits(trace_word_bits), .trace_word_valid(trace_word_valid),
        .trig_req(trig_req), .probe_trigger_in(probe_trigger_in),
        .onchip_trigger_in(onchip_trigger_in),
        .probe_trig_event(probe_trig_event),
        .onchip_trig_event(onchip_trig_event),
        .probe_trigger_out(probe_trigger_out),
        .onchip_trigger_out(onchip_trigger_out));

    twop_piu_model u_twop_piu_model (.sys_clk(sys_clk),
        .trace_word_bits(trace_word_bits), .trace_word_valid(trace_word_valid),
        .cfg_count(cfg_count), .cfg_hold(cfg_hold),
        .trace_bit_count(trace_bit_count),
        .trace_hold_request(trace_hold_request), .lane_bits(lane_bits),
        .got_word(got_word));

    // Compares one observed value with its expectation and tallies both.
    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the tallies and the verdict, then stops the run.
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Back-to-back words with a hold in between; the held word must freeze.
    task automatic t_full;
        @(posedge sys_clk);
        src <= '{valid: 1'b1, data: 64'h0123_4567_89ab_cdef};
        @(posedge sys_clk);
        src <= '{valid: 1'b1, data: 64'hfedc_ba98_7654_3210};
        cfg_hold <= 1'b1;
        repeat (3)
        begin
            @(negedge sys_clk);
            check("held bits", trace_word_bits, 64'h0123_4567_89ab_cdef);
            check("held valid", 64'(trace_word_valid), 64'h1);
        end
        @(posedge sys_clk);
        cfg_hold <= 1'b0;
        @(posedge sys_clk);
        src <= '{valid: 1'b0, data: 64'h0};
        @(negedge sys_clk);
        check("new bits", trace_word_bits, 64'hfedc_ba98_7654_3210);
        check("new valid", 64'(trace_word_valid), 64'h1);
        @(negedge sys_clk);
        check("idle valid", 64'(trace_word_valid), 64'h0);
        check("probe word", got_word, 64'hfedc_ba98_7654_3210);
    endtask

    // 32-bit chunks: hold is ignored, valid stays low, data shifts down.
    task automatic t_narrow;
        @(posedge sys_clk);
        cfg_count <= 3'h3;
        cfg_hold <= 1'b1;
        src <= '{valid: 1'b1, data: 64'haaaa_5555_1234_8765};
        repeat (20)
        begin
            @(negedge sys_clk);
            if (src_ready === 1'b1)
                break;
        end
        check("ready under hold", 64'(src_ready), 64'h1);
        @(posedge sys_clk);
        src <= '{valid: 1'b0, data: 64'h0};
        @(negedge sys_clk);
        check("narrow bits", trace_word_bits, 64'haaaa_5555_1234_8765);
        check("narrow valid", 64'(trace_word_valid), 64'h0);
        @(negedge sys_clk);
        check("shifted bits", trace_word_bits, 64'h0000_0000_aaaa_5555);
        check("lane bits", 64'(lane_bits), 64'h5555);
        @(posedge sys_clk);
        cfg_hold <= 1'b0;
    endtask

    // Probe strobe length follows the trace cycle of count codes 0 to 4.
    task automatic t_probe_strobe;
        int highs;
        for (int c = 0; c <= 4; c++)
        begin
            @(posedge sys_clk);
            cfg_count <= c[2:0];
            trig_req.probe <= 1'b1;
            @(posedge sys_clk);
            trig_req.probe <= 1'b0;
            highs = 0;
            repeat (20)
            begin
                @(negedge sys_clk);
                if (probe_trigger_out === 1'b1)
                    highs++;
            end
            check("probe strobe", 64'(highs), 64'(16 >> c));
        end
    endtask

    // On-chip strobe lasts one core cycle; pins give one event per edge.
    task automatic t_onchip_and_pins;
        int ons;
        int pev;
        int oev;
        ons = 0;
        pev = 0;
        oev = 0;
        @(posedge sys_clk);
        trig_req.onchip <= 1'b1;
        probe_trigger_in <= 1'b1;
        onchip_trigger_in <= 1'b1;
        @(posedge sys_clk);
        trig_req.onchip <= 1'b0;
        @(negedge sys_clk);
        check("early event", 64'(probe_trig_event), 64'h0);
        ons += int'(onchip_trigger_out === 1'b1);
        repeat (8)
        begin
            @(negedge sys_clk);
            ons += int'(onchip_trigger_out === 1'b1);
            pev += int'(probe_trig_event === 1'b1);
            oev += int'(onchip_trig_event === 1'b1);
        end
        check("onchip strobe", 64'(ons), 64'h1);
        check("probe events", 64'(pev), 64'h1);
        check("onchip events", 64'(oev), 64'h1);
    endtask

    // The clock toggles each half period of 12.5 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Main sequence: reset for 12 cycles, then each scenario in turn.
    initial
    begin
        err_count = 0;
        total_checks = 0;
        rst_b = 1'b0;
        src = '{valid: 1'b0, data: 64'h0};
        trig_req = '{probe: 1'b0, onchip: 1'b0};
        probe_trigger_in = 1'b0;
        onchip_trigger_in = 1'b0;
        cfg_count = 3'h4;
        cfg_hold = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_full();
        t_narrow();
        t_probe_strobe();
        t_onchip_and_pins();
        complete_run();
    end

    // Watchdog sized well past the 150 or so cycles the tests need.
    initial
    begin
        #(25 * 5000);
        err_count++;
        complete_run();
    end
endmodule
